// ===== core/lhd_header_check.sv
// Notes on behaviour
// RULE1 - invalid header sets header error flag
// RULE2 - irq needs enable and mask bits clear
// RULE3 - software clears state flag, then error flag
// RULE4 - status access then data read clears flag
// RULE5 - no resync: synch byte not 55h errors
// RULE6 - no resync: overrun sets header error
// RULE7 - timeout reported only with detect method set
// RULE8 - resync: excessive synch deviation errors
// RULE9 - resync: measurement overflow errors and blocks
// RULE10 - resync: overrun flagged outside synch field
// RULE11 - compare own bit rate, two parallel checks
// RULE12 - first-to-last falling edge span check
// RULE13 - each edge interval must not be short
// RULE14 - deviation failure sets synch state flag
// RULE15 - header must finish within 57 bit times
// RULE16 - timer starts on break, stops on events
`timescale 1ns/1ns
`default_nettype none
`include "lhd_consts.svh"

module lhd_header_check (
    input  wire logic               core_clk_i,
    input  wire logic               rst_n_i,
    input  wire logic               ce_i,
    input  wire logic               serial_receive_input_i,
    input  wire logic               break_det_i,
    input  wire lhd_pkg::lhd_byte_t rx_data_i,
    input  wire logic               rx_valid_i,
    output logic                    rx_ready_o,
    output lhd_pkg::lhd_byte_t      data_o,
    output logic                    data_valid_o,
    input  wire logic               data_read_i,
    input  wire logic               status_access_i,
    input  wire logic               auto_resync_enable_i,
    input  wire logic               header_detect_method_i,
    input  wire logic               receive_irq_enable_i,
    input  wire logic [1:0]         cpu_int_mask_i,
    input  wire logic               synch_field_clr_i,
    input  wire logic [15:0]        bit_period_i,
    output logic                    header_error_flag_o,
    output logic                    synch_field_state_flag_o,
    output logic                    irq_o
);
    import lhd_pkg::*;

    function automatic logic [19:0] scale(input logic [15:0] bp, input int num, input int sh);
        logic [35:0] prod;
        prod  = 36'(bp) * 36'(num);
        scale = 20'(prod >> sh);
    endfunction

    // =================================================================
    // pin synchroniser and edge detect
    logic rx_s1_r;
    logic rx_s2_r;
    logic rx_d_r;
    wire  fall = rx_d_r & ~rx_s2_r;
    wire  rise = ~rx_d_r & rx_s2_r;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_d_r  <= 1'b1;
        end else if (ce_i) begin
            rx_s1_r <= serial_receive_input_i;
            rx_s2_r <= rx_s1_r;
            rx_d_r  <= rx_s2_r;
        end
    end

    // =================================================================
    // state and counters
    lhd_state_e  st_r;
    lhd_state_e  st_nxt;
    logic [19:0] span_r;
    logic [15:0] edge_r;
    logic [2:0]  falls_r;
    logic        tmr_on_r;
    logic [15:0] tcyc_r;
    logic [5:0]  tbits_r;
    logic        hdr_err_r;
    logic        blk_flag_r;
    logic        armed_r;

    wire resync_en = auto_resync_enable_i;
    wire in_sync   = (st_r == LHD_ST_WAIT) || (st_r == LHD_ST_MEAS);
    wire blocked   = blk_flag_r & resync_en;

    // =================================================================
    // receive buffer, overrun when receiver finds it full
    logic buf_ready;
    lhd_buf2 u_buf (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .ce_i        (ce_i),
        .in_data_i   (rx_data_i),
        .in_valid_i  (rx_valid_i),
        .in_ready_o  (buf_ready),
        .out_data_o  (data_o),
        .out_valid_o (data_valid_o),
        .out_ready_i (data_read_i)
    );
    assign rx_ready_o = buf_ready;

    wire ovr       = rx_valid_i & ~buf_ready;
    wire synch_fld = in_sync || (st_r == LHD_ST_SYNCB);
    wire ovr_err   = ovr & (~resync_en | ~synch_fld);                      // [RULE6] [RULE10]
    wire byte_in   = rx_valid_i & buf_ready;
    wire synch_err = ~resync_en & byte_in & (st_r == LHD_ST_SYNCB)
                     & (rx_data_i != `LHD_SYNCH_PATTERN);                  // [RULE5]

    // =================================================================
    // synch field deviation checks
    wire [19:0] span_nom  = {1'b0, bit_period_i, 3'b000};
    wire [19:0] span_tol  = scale(bit_period_i, `LHD_DEV_NUM, `LHD_DEV_SH);
    wire [19:0] short_lim = scale(bit_period_i, `LHD_SHORT_NUM, `LHD_SHORT_SH);
    wire        last_fall = (st_r == LHD_ST_MEAS) & fall & (falls_r == `LHD_SYNCH_FALLS - 3'd1);
    wire [19:0] span_diff = (span_r > span_nom) ? span_r - span_nom : span_nom - span_r;
    wire        span_err  = resync_en & last_fall & (span_diff > span_tol); // [RULE8] [RULE11] [RULE12]
    wire        short_err = resync_en & (st_r == LHD_ST_MEAS) & (fall | rise)
                            & ({4'h0, edge_r} < short_lim);                // [RULE13]
    wire        ovf_err   = resync_en & (st_r == LHD_ST_MEAS) & (span_r == `LHD_SPAN_MAX); // [RULE9]
    wire        dev_err   = span_err | short_err;

    // =================================================================
    // header timeout
    wire tmo_hit = tmr_on_r & (tbits_r == `LHD_HDR_MAX_BITS);              // [RULE15]
    wire tmo_err = tmo_hit & header_detect_method_i;                       // [RULE7]
    wire other_err = synch_err | ovr_err | dev_err | ovf_err;
    wire tmr_stop  = (byte_in & (st_r == LHD_ST_IDENT)) | other_err
                     | (blk_flag_r & synch_field_clr_i & in_sync) | tmo_hit; // [RULE16]
    wire brk_go    = break_det_i & ~blocked;

    wire err_set   = other_err | tmo_err;                                  // [RULE1]
    wire blk_set   = dev_err | ovf_err | (resync_en & tmo_err & in_sync);  // [RULE14] [RULE9]
    wire err_clr   = armed_r & data_read_i & data_valid_o;                 // [RULE4]

    always_comb begin
        st_nxt = st_r;
        if (brk_go) begin
            st_nxt = resync_en ? LHD_ST_WAIT : LHD_ST_SYNCB;
        end else if (err_set || tmo_hit) begin
            st_nxt = LHD_ST_IDLE;
        end else begin
            case (st_r)
                LHD_ST_IDLE: begin
                    st_nxt = LHD_ST_IDLE;
                end
                LHD_ST_WAIT: begin
                    if (fall) st_nxt = LHD_ST_MEAS;
                end
                LHD_ST_MEAS: begin
                    if (last_fall) st_nxt = LHD_ST_SYNCB;
                end
                LHD_ST_SYNCB: begin
                    if (byte_in) st_nxt = LHD_ST_IDENT;
                end
                LHD_ST_IDENT: begin
                    if (byte_in) st_nxt = LHD_ST_IDLE;
                end
                default: begin
                    st_nxt = LHD_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_r <= LHD_ST_IDLE;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // measurement counters, span saturates to expose overflow
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            span_r  <= 20'h0_0000;
            edge_r  <= 16'h0000;
            falls_r <= 3'd0;
        end else if (ce_i) begin
            if (st_r != LHD_ST_MEAS) begin
                span_r  <= 20'h0_0001;
                edge_r  <= 16'h0001;
                falls_r <= 3'd1;
            end else begin
                if (span_r != `LHD_SPAN_MAX) span_r <= span_r + 20'h0_0001;
                if (fall | rise) edge_r <= 16'h0001;
                else if (edge_r != `LHD_EDGE_MAX) edge_r <= edge_r + 16'h0001;
                if (fall) falls_r <= falls_r + 3'd1;
            end
        end
    end

    // bit time counter for the header timeout
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            tmr_on_r <= 1'b0;
            tcyc_r   <= 16'h0000;
            tbits_r  <= 6'd0;
        end else if (ce_i) begin
            if (brk_go) begin
                tmr_on_r <= 1'b1;                                          // [RULE16]
                tcyc_r   <= 16'h0001;
                tbits_r  <= 6'd0;
            end else if (tmr_stop) begin
                tmr_on_r <= 1'b0;
            end else if (tmr_on_r) begin
                if (tcyc_r >= bit_period_i) begin
                    tcyc_r  <= 16'h0001;
                    tbits_r <= tbits_r + 6'd1;
                end else begin
                    tcyc_r <= tcyc_r + 16'h0001;
                end
            end
        end
    end

    // =================================================================
    // flags: hardware set wins over software clear
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            hdr_err_r  <= 1'b0;
            blk_flag_r <= 1'b0;
            armed_r    <= 1'b0;
        end else if (ce_i) begin
            if (err_set) hdr_err_r <= 1'b1;
            else if (err_clr) hdr_err_r <= 1'b0;
            if (blk_set) blk_flag_r <= 1'b1;                               // [RULE3]
            else if (synch_field_clr_i) blk_flag_r <= 1'b0;
            if (status_access_i) armed_r <= 1'b1;
            else if (err_clr) armed_r <= 1'b0;
        end
    end

    assign header_error_flag_o      = hdr_err_r;
    assign synch_field_state_flag_o = blk_flag_r;
    assign irq_o = hdr_err_r & receive_irq_enable_i & (cpu_int_mask_i == 2'b00); // [RULE2]

    // =================================================================
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence seq_brk;
        ce_i && break_det_i && !blocked;
    endsequence
    sequence seq_timing;
        tmr_on_r && tbits_r == 6'd0;
    endsequence

    sequence seq_err_open;
        ce_i && err_set ##1 receive_irq_enable_i && cpu_int_mask_i == 2'b00;
    endsequence

    irq_gate_a: assert property (irq_o |-> hdr_err_r && receive_irq_enable_i && cpu_int_mask_i == 2'b00) // [RULE2]
        else $error("irq without enable or with mask set");
    irq_raise_a: assert property (seq_err_open |-> irq_o) // [RULE2]
        else $error("header error did not raise irq");
    synch_byte_a: assert property (ce_i && synch_err |=> hdr_err_r && st_r == LHD_ST_IDLE) // [RULE5]
        else $error("bad synch byte not flagged");
    flag_clear_a: assert property (ce_i && armed_r && data_read_i && data_valid_o && !err_set |=> !hdr_err_r) // [RULE4]
        else $error("header error flag not cleared");
    ovr_flag_a: assert property (ce_i && rx_valid_i && !rx_ready_o && !resync_en |=> hdr_err_r) // [RULE6]
        else $error("overrun not flagged");
    tmo_method_a: assert property (ce_i && tmo_hit && !other_err && !hdr_err_r // [RULE7]
        && !header_detect_method_i |=> !hdr_err_r)
        else $error("timeout flagged without detect method");
    ovf_block_a: assert property (ce_i && ovf_err |=> blk_flag_r && hdr_err_r) // [RULE9]
        else $error("overflow did not block");
    dev_block_a: assert property (ce_i && dev_err |=> blk_flag_r && hdr_err_r && st_r == LHD_ST_IDLE) // [RULE14]
        else $error("deviation did not block");
    brk_block_a: assert property (ce_i && break_det_i && blocked && st_r == LHD_ST_IDLE // [RULE14]
        |=> st_r == LHD_ST_IDLE)
        else $error("break accepted while blocked");
    tmr_start_a: assert property (seq_brk |=> seq_timing) // [RULE16]
        else $error("timeout counter not started on break");
    tmo_hit_a: assert property (ce_i && tmo_err |=> hdr_err_r && !tmr_on_r) // [RULE15]
        else $error("timeout not reported");
endmodule

`default_nettype wire

// ===== core/lhd_consts.svh
`ifndef LHD_CONSTS_SVH
`define LHD_CONSTS_SVH

// =====================================================================
// header check constants
`define LHD_SYNCH_PATTERN   8'h55
`define LHD_HDR_MAX_BITS    6'd57
`define LHD_SYNCH_FALLS     3'd5
`define LHD_SPAN_MAX        20'hF_FFFF
`define LHD_SPAN_BITS_SH    3
`define LHD_DEV_NUM         5
`define LHD_DEV_SH          2
`define LHD_SHORT_NUM       27
`define LHD_SHORT_SH        5
`define LHD_EDGE_MAX        16'hFFFF
`define LHD_BUF_DEPTH       2
`define LHD_DATA_W          8

`endif

// ===== core/lhd_pkg.sv
`default_nettype none
package lhd_pkg;
    typedef enum logic [2:0] {
        LHD_ST_IDLE   = 3'b000,
        LHD_ST_WAIT   = 3'b001,
        LHD_ST_MEAS   = 3'b010,
        LHD_ST_SYNCB  = 3'b011,
        LHD_ST_IDENT  = 3'b100
    } lhd_state_e;

    typedef logic [7:0] lhd_byte_t;
endpackage

`default_nettype wire

// ===== core/lhd_buf2.sv
`timescale 1ns/1ns
`default_nettype none
`include "lhd_consts.svh"

module lhd_buf2 (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    input  wire lhd_pkg::lhd_byte_t in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output lhd_pkg::lhd_byte_t    out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    import lhd_pkg::*;

    lhd_byte_t  mem_r [`LHD_BUF_DEPTH];
    logic       wr_ptr_r;
    logic       rd_ptr_r;
    logic [1:0] cnt_r;
    wire        push = in_valid_i & in_ready_o;
    wire        pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (cnt_r != 2'(`LHD_BUF_DEPTH));
    assign out_valid_o = (cnt_r != 2'd0);
    assign out_data_o  = mem_r[rd_ptr_r];

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            cnt_r    <= 2'd0;
            mem_r[0] <= 8'h00;
            mem_r[1] <= 8'h00;
        end else if (ce_i) begin
            if (push) begin
                mem_r[wr_ptr_r] <= in_data_i;
                wr_ptr_r        <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

`default_nettype wire

// ===== test/lhd_lin_master.sv
`timescale 1ns/1ns
`default_nettype none
module lhd_lin_master (
    input  wire logic          core_clk_i,
    output logic               pin_o,
    output logic               brk_o,
    output lhd_pkg::lhd_byte_t data_o,
    output logic               valid_o
);
    import lhd_pkg::*;
    initial begin
        pin_o = 1'b1;
        brk_o = 1'b0;
        data_o = 8'h00;
        valid_o = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #10;
    endtask
    task automatic brk();
        brk_o = 1'b1;
        cyc(1);
        brk_o = 1'b0;
        cyc(1);
    endtask
    // 55h frame on the pin; bit 3 shortened, bit 4 stretched by odd
    task automatic synch(input int bp, input int odd);
        logic [9:0] v;
        v = {1'b1, 8'h55, 1'b0};
        for (int i = 0; i < 10; i++) begin
            pin_o = v[i];
            cyc(bp - ((i == 3) ? odd : 0) + ((i == 4) ? odd : 0));
        end
        cyc(4);
    endtask
    // released data shows the inverse of the last byte
    task automatic put_byte(input lhd_byte_t b);
        data_o = b;
        valid_o = 1'b1;
        cyc(1);
        valid_o = 1'b0;
        data_o = ~b;
        cyc(1);
    endtask
endmodule
`default_nettype wire

// ===== test/lhd_header_check_test.sv
`timescale 1ns/1ns
`default_nettype none
module lhd_header_check_test;
    import lhd_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        rst_n_i    = 1'b0;
    logic        pin, brk, rxv, rdy, dv, hef, sff, irq;
    logic        rd = 0, sa = 0, are = 0, hdm = 0, irq_en = 0, sclr = 0, ce = 1;
    logic [1:0]  msk = 2'h0;
    lhd_byte_t   rxd, dout, b;
    int          errors = 0;
    int          check_count = 0;
    int          fill = 0;
    logic [19:0] lf = 20'h1_062A;
    lhd_byte_t   q[$];
    int          cs[6][3] = '{'{16,0,0}, '{15,0,0}, '{13,0,1}, '{16,5,1}, '{18,0,0}, '{20,0,1}};

    always #50 core_clk_i = ~core_clk_i;

    lhd_lin_master lhd_lin_master_inst (.core_clk_i(core_clk_i), .pin_o(pin), .brk_o(brk),
        .data_o(rxd), .valid_o(rxv));
    lhd_header_check lhd_header_check_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
        .serial_receive_input_i(pin), .break_det_i(brk), .rx_data_i(rxd), .rx_valid_i(rxv),
        .rx_ready_o(rdy), .data_o(dout), .data_valid_o(dv), .data_read_i(rd), .status_access_i(sa),
        .auto_resync_enable_i(are), .header_detect_method_i(hdm), .receive_irq_enable_i(irq_en),
        .cpu_int_mask_i(msk), .synch_field_clr_i(sclr), .bit_period_i(16'h0010),
        .header_error_flag_o(hef), .synch_field_state_flag_o(sff), .irq_o(irq));

    // ==========================================
    // checking
    task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wrap_up();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        if (ce && rd && dv && q.size() > 0) begin
            chk(dout, q.pop_front(), "data");
        end
    end
    initial begin
        #(20000 * 100);
        errors++;
        wrap_up();
    end

    // ==========================================
    // stimulus
    function lhd_byte_t rnd();
        lf = {lf[18:0], lf[19] ^ lf[16]};
        return lf[7:0] ^ lf[15:8];
    endfunction
    task cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #10;
    endtask
    task flags(input logic e_h, input logic e_s);
        cyc(1);
        chk(8'(hef), 8'(e_h), "header_error");
        chk(8'(sff), 8'(e_s), "synch_state");
    endtask
    task rx(input lhd_byte_t v);
        chk(8'(rdy), 8'(fill < 2), "rx_ready");
        if (fill < 2) begin
            q.push_back(v);
            fill++;
        end
        lhd_lin_master_inst.put_byte(v);
    endtask
    task rd_one();
        chk(8'(dv), 8'(fill != 0), "data_valid");
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        if (fill > 0) fill--;
        cyc(1);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(1);
    endtask

    initial begin
        cyc(2);
        rst_n_i = 1'b1;
        flags(0, 0);
        chk(8'(irq), 8'h00, "irq");
        lhd_lin_master_inst.brk();
        rx(8'h55);
        rx(rnd());
        flags(0, 0);
        rd_one();
        rd_one();
        b = rnd();
        if (b == 8'h55) b = 8'h54;
        lhd_lin_master_inst.brk();
        rx(b);
        rx(rnd());
        flags(1, 0);
        for (int i = 0; i < 8; i++) begin
            irq_en = i[2];
            msk = i[1:0];
            cyc(1);
            chk(8'(irq), 8'(i == 4), "irq");
        end
        msk = 2'b00;
        rd_one();
        flags(1, 0);
        pulse(sa);
        rd_one();
        flags(0, 0);
        lhd_lin_master_inst.brk();
        rx(8'h55);
        rx(rnd());
        rx(rnd());
        flags(1, 0);
        pulse(sa);
        rd_one();
        rd_one();
        for (int i = 0; i < 2; i++) begin
            hdm = i[0];
            lhd_lin_master_inst.brk();
            cyc(57 * 16 - 6);
            flags(0, 0);
            cyc(10);
            flags(i[0], 0);
            rx(8'h55);
            pulse(sa);
            rd_one();
            flags(0, 0);
        end
        lhd_lin_master_inst.brk();
        rx(8'h55);
        rx(rnd());
        cyc(57 * 16);
        flags(0, 0);
        rd_one();
        rd_one();
        hdm = 1'b0;
        are = 1'b1;
        for (int i = 0; i < 6; i++) begin
            lhd_lin_master_inst.brk();
            lhd_lin_master_inst.synch(cs[i][0], cs[i][1]);
            rx(8'h55);
            rx(rnd());
            flags(cs[i][2][0], cs[i][2][0]);
            if (cs[i][2][0]) lhd_lin_master_inst.brk();
            flags(cs[i][2][0], cs[i][2][0]);
            pulse(sclr);
            pulse(sa);
            rd_one();
            rd_one();
            flags(0, 0);
        end
        lhd_lin_master_inst.brk();
        lhd_lin_master_inst.synch(16, 0);
        rx(8'h55);
        rx(rnd());
        rx(rnd());
        flags(1, 0);
        pulse(sa);
        rd_one();
        rd_one();
        rx(rnd());
        rx(rnd());
        lhd_lin_master_inst.brk();
        lhd_lin_master_inst.synch(16, 0);
        rx(8'h55);
        flags(0, 0);
        rd_one();
        rd_one();
        rx(rnd());
        rx(rnd());
        rx(rnd());
        flags(1, 0);
        chk(8'(irq), 8'h01, "irq");
        pulse(sa);
        ce = 1'b0;
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        chk(8'(dv), 8'h01, "data_valid");
        chk(8'(hef), 8'h01, "header_error");
        ce = 1'b1;
        rst_n_i = 1'b0;
        cyc(2);
        rst_n_i = 1'b1;
        q.delete();
        fill = 0;
        flags(0, 0);
        chk(8'(dv), 8'h00, "data_valid");
        chk(8'(rdy), 8'h01, "rx_ready");
        chk(8'(irq), 8'h00, "irq");
        wrap_up();
    end
endmodule
`default_nettype wire
